// ==== design/lbc_defs.svh ====
// Timing counts and slot constants for the local-bus controller
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
`define LBC_NUM_SLOTS      2
`define LBC_CLK_PERIOD_NS  4
`define LBC_GRANT_TIME_NS  400
`define LBC_GRANT_CYCLES   (`LBC_GRANT_TIME_NS / `LBC_CLK_PERIOD_NS)
`define LBC_RDYRTN_DELAY   1'h1
`endif

// ==== design/lbc_pkg.sv ====
// Types shared by the local-bus controller
package lbc_pkg;
  typedef enum logic [2:0] {
    LBC_IDLE,
    LBC_OWNED,
    LBC_CPU_CYCLE,
    LBC_WAIT_READY,
    LBC_RETURN
  } lbc_state_t;
endpackage : lbc_pkg

// ==== design/lbc_controller.sv ====
// Motherboard local-bus controller: arbitration, ready return, cache enable, strobes
// Operation
// RL1 - Owner asserts invalidation strobe on invalidation addresses
// RL2 - Granted master drives strobe throughout ownership
// RL3 - Caching master may invalidate on strobe
// RL4 - Strobe stays inactive on CPU writes
// RL5 - Low request answered by same-slot grant
// RL6 - Master keeps bus; controller may preempt
// RL7 - Separate request and grant per slot
// RL8 - Target-only devices leave request high
// RL9 - Only controller drives cache enable
// RL10 - Cache enable one clock before ready
// RL11 - Target drives ready only in claim
// RL12 - Cycle stays open until ready low
// RL13 - Ready low one clock, high, release
// RL14 - Ready changes only on clock edges
// RL15 - No ready first T2 unless fast write
// RL16 - Status high memory, low I/O
// RL17 - Status driver depends on cycle type
// RL18 - Controller returns ready-return to end cycle
// RL19 - Fast-write bit only if zero-wait capable
// RL20 - Preempted master finishes, releases, re-requests
`include "lbc_defs.svh"
module lbc_controller #(
  parameter int NUM_SLOTS   = `LBC_NUM_SLOTS,
  parameter int GRANT_LIMIT = `LBC_GRANT_CYCLES
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic [NUM_SLOTS-1:0] lreq_n_in,
  output logic      [NUM_SLOTS-1:0] lgnt_n_out,
  input  wire logic                 lrdy_n_in,
  output logic                      rdyrtn_n_out,
  output logic                      lken_n_out,
  output logic                      leads_n_out,
  output logic                      leads_oe_out,
  input  wire logic                 leads_n_in,
  output logic                      mio_out,
  output logic                      mio_oe_out,
  input  wire logic                 cyc_start_in,
  input  wire logic                 cyc_write_in,
  input  wire logic                 cyc_inval_in,
  input  wire logic                 cyc_cacheable_in,
  input  wire logic                 cyc_last_in,
  input  wire logic                 dma_active_in,
  input  wire logic                 dma_memr_in,
  input  wire logic                 dma_memw_in,
  input  wire logic                 fast_rdyrtn_in,
  output logic                      cyc_busy_out,
  output logic                      cyc_done_out,
  output logic                      bus_owned_out,
  output logic                      leads_seen_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three flops, change taken when stages two and three agree
  logic [NUM_SLOTS-1:0] req_s1_reg, req_s2_reg, req_s3_reg, req_reg;
  logic [2:0]           lds_sh_reg;   // Strobe sampler stages
  logic                 lds_reg;      // Filtered strobe, active high
  // Ready is a one-clock pulse launched on our own clock edges, so it is read
  // directly: a filter that needs two agreeing stages would swallow it
  wire                  rdy_now = ~lrdy_n_in;
  // Ready is seen no earlier than the first wait clock, so zero-wait writes
  // cannot be taken and the fast-write capability stays clear [RL19]
  localparam logic      HS_WRITE_OK = 1'b0;

  // Low request filtered to active-high per slot [RL7]
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_s1_reg <= '0;
      req_s2_reg <= '0;
      req_s3_reg <= '0;
      req_reg    <= '0;
      lds_sh_reg <= 3'h0;
      lds_reg    <= 1'b0;
    end else begin
      req_s1_reg <= ~lreq_n_in;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      req_reg    <= (req_s2_reg & req_s3_reg) | (req_reg & (req_s2_reg | req_s3_reg));
      lds_sh_reg <= {lds_sh_reg[1:0], ~leads_n_in};
      if (lds_sh_reg[1] == lds_sh_reg[2]) begin
        lds_reg <= lds_sh_reg[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration: fixed priority, lowest slot wins
  lbc_pkg::lbc_state_t  state_reg, state_next;
  logic [NUM_SLOTS-1:0] grant_reg, grant_next;   // One-hot grant
  logic [15:0]          own_cnt_reg;             // Ownership length
  logic                 write_reg;               // Cycle is a write
  logic                 cache_reg;               // Cycle is cacheable
  logic                 last_reg;                // Last read of a line
  logic                 rtn_wait_reg;            // Ready seen, return pending

  // Lowest set request bit, used for the grant decision
  function automatic logic [NUM_SLOTS-1:0] lbc_pick(input logic [NUM_SLOTS-1:0] r);
    logic [NUM_SLOTS-1:0] p;
    p = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (r[i]) begin
        p = '0;
        p[i] = 1'b1;
      end
    end
    return p;
  endfunction : lbc_pick

  wire                 any_req   = |req_reg;
  wire [NUM_SLOTS-1:0] pick      = lbc_pick(req_reg);
  wire                 owner_req = |(grant_reg & req_reg);
  // Preempt after a long tenure when another slot waits
  wire                 preempt   = (own_cnt_reg >= 16'(GRANT_LIMIT)) &&
                                   |(req_reg & ~grant_reg);

  // Next-state decode
  always_comb begin
    state_next = state_reg;
    grant_next = grant_reg;
    case (state_reg)
      lbc_pkg::LBC_IDLE: begin
        if (any_req) begin
          grant_next = pick;                          // [RL5]
          state_next = lbc_pkg::LBC_OWNED;
        end else if (cyc_start_in) begin
          state_next = lbc_pkg::LBC_CPU_CYCLE;
        end
      end
      lbc_pkg::LBC_OWNED: begin
        // Master keeps the bus until it drops its request, or is preempted [RL6]
        // A removed grant relies on the master finishing and re-requesting [RL20]
        if (!owner_req || preempt) begin
          grant_next = '0;
          state_next = lbc_pkg::LBC_IDLE;
        end
      end
      lbc_pkg::LBC_CPU_CYCLE: begin
        state_next = lbc_pkg::LBC_WAIT_READY;
      end
      lbc_pkg::LBC_WAIT_READY: begin
        // Not-ready bus: the cycle stays open until ready arrives [RL12]
        // Fast mode returns on ready itself, slow mode on the remembered ready
        if ((rdy_now && fast_rdyrtn_in) || rtn_wait_reg) begin
          state_next = lbc_pkg::LBC_RETURN;
        end
      end
      lbc_pkg::LBC_RETURN: begin
        state_next = lbc_pkg::LBC_IDLE;
      end
      default: begin
        state_next = lbc_pkg::LBC_IDLE;
        grant_next = '0;
      end
    endcase
  end

  // State, grant and cycle attributes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg    <= lbc_pkg::LBC_IDLE;
      grant_reg    <= '0;
      own_cnt_reg  <= 16'h0000;
      write_reg    <= 1'b0;
      cache_reg    <= 1'b0;
      last_reg     <= 1'b0;
      rtn_wait_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      grant_reg    <= grant_next;
      own_cnt_reg  <= (state_reg == lbc_pkg::LBC_OWNED && own_cnt_reg != 16'hFFFF) ?
                      own_cnt_reg + 16'h0001 : 16'h0000;
      // Slow mode returns two clocks after ready, one clock later than fast mode [RL18]
      rtn_wait_reg <= (state_reg == lbc_pkg::LBC_WAIT_READY) && rdy_now && !rtn_wait_reg;
      if (state_reg == lbc_pkg::LBC_IDLE && cyc_start_in && !any_req) begin
        write_reg <= cyc_write_in;
        cache_reg <= cyc_cacheable_in && !cyc_write_in;
        last_reg  <= cyc_last_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic rdyrtn_reg, lken_reg, leads_reg, mio_reg, mio_oe_reg, leads_seen_reg;
  wire  in_cpu    = (state_reg == lbc_pkg::LBC_CPU_CYCLE) ||
                    (state_reg == lbc_pkg::LBC_WAIT_READY);
  wire  owned     = (state_reg == lbc_pkg::LBC_OWNED);
  // Invalidation strobe only when controller owns and not on CPU writes [RL1] [RL4]
  wire  start_take = (state_reg == lbc_pkg::LBC_IDLE) && cyc_start_in && !any_req;
  // Write blocks the strobe from the edge it is taken, not one clock late [RL4]
  wire  cpu_write = (in_cpu && write_reg) || (start_take && cyc_write_in);
  wire  leads_nxt = cyc_inval_in && !owned && !cpu_write && !dma_active_in;

  // Outputs and pin drive
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdyrtn_reg     <= 1'b0;
      lken_reg       <= 1'b0;
      leads_reg      <= 1'b0;
      mio_reg        <= 1'b1;
      mio_oe_reg     <= 1'b0;
      leads_seen_reg <= 1'b0;
    end else begin
      rdyrtn_reg     <= (state_next == lbc_pkg::LBC_RETURN);    // [RL18]
      // Cacheable last read of a line: held from before ready until the return [RL9] [RL10]
      lken_reg       <= cache_reg && last_reg && (state_next == lbc_pkg::LBC_WAIT_READY ||
                        state_next == lbc_pkg::LBC_RETURN);
      leads_reg      <= leads_nxt;
      // DMA cycles: status from memory strobes, high memory, low I/O [RL16] [RL17]
      mio_reg        <= dma_memr_in || dma_memw_in;
      // Dropped on the edge a grant or CPU cycle begins: no overlap with a master
      mio_oe_reg     <= dma_active_in && (state_next == lbc_pkg::LBC_IDLE);
      // Strobe seen while a master owns the bus [RL2]
      leads_seen_reg <= owned && lds_reg;
    end
  end

  // Pins; the master drives strobe and status when owned, so ours are released
  assign lgnt_n_out     = ~grant_reg;
  assign rdyrtn_n_out   = ~rdyrtn_reg;
  assign lken_n_out     = ~lken_reg;
  assign leads_n_out    = ~leads_reg;
  assign leads_oe_out   = !owned;
  assign mio_out        = mio_reg;
  assign mio_oe_out     = mio_oe_reg;
  assign cyc_busy_out   = in_cpu || (state_reg == lbc_pkg::LBC_RETURN);
  assign cyc_done_out   = rdyrtn_reg;
  assign bus_owned_out  = owned;
  assign leads_seen_out = leads_seen_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_grant_onehot: assert property (@(posedge clk_in) disable iff (reset_in) // [RL7]
    $onehot0(grant_reg)) else $error("two grants at once");
  a_grant_needs_req: assert property (@(posedge clk_in) disable iff (reset_in) // [RL5]
    $rose(|grant_reg) |-> |(grant_reg & req_reg)) else $error("grant without request");
  a_rtn_after_rdy: assert property (@(posedge clk_in) disable iff (reset_in) // [RL12]
    rdyrtn_reg |-> $past(rdy_now) || $past(rtn_wait_reg)) else $error("return without ready");
  a_rtn_one_cycle: assert property (@(posedge clk_in) disable iff (reset_in) // [RL18]
    rdyrtn_reg |=> !rdyrtn_reg) else $error("return longer than one");
  a_leads_no_write: assert property (@(posedge clk_in) disable iff (reset_in) // [RL4]
    (cyc_busy_out && write_reg) |-> !leads_reg) else $error("strobe on write");
  a_lken_ends_rtn: assert property (@(posedge clk_in) disable iff (reset_in) // [RL10]
    (lken_reg && rdyrtn_reg) |=> !lken_reg) else $error("cache enable past return");
  a_lken_read_only: assert property (@(posedge clk_in) disable iff (reset_in) // [RL9]
    lken_reg |-> !write_reg) else $error("cache enable on write");
  a_mio_dma_only: assert property (@(posedge clk_in) disable iff (reset_in) // [RL17]
    mio_oe_reg |-> !owned) else $error("status driven against master");
  a_write_not_zws: assert property (@(posedge clk_in) disable iff (reset_in) // [RL19]
    (state_reg == lbc_pkg::LBC_CPU_CYCLE) |=> !rdyrtn_reg || HS_WRITE_OK)
    else $error("zero-wait return");
endmodule : lbc_controller

// ==== bench/lbc_device_model.sv ====
// Add-in device model: per-slot requester, ready-driving target, strobe owner
module lbc_device_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] want_in,      // Bench wants the bus, per slot
  input  wire logic [1:0] lgnt_n_in,    // Grants from controller
  output logic      [1:0] lreq_n_out,   // Requests, high when idle
  input  wire logic       start_in,     // Cycle claimed by this target
  input  wire logic [1:0] wait_in,      // Extra wait states
  output logic            lrdy_n_out,   // Resolved ready line
  input  wire logic       inval_in,     // Master shows invalidation address
  output logic            leads_n_out,  // Strobe drive
  output logic            leads_oe_out  // High while a slot owns the bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gone_reg;  // Grant lost, request held off until want drops
  logic [1:0] prev_reg;  // Grant one clock ago
  logic [2:0] cnt_reg;   // Wait-state counter
  logic [1:0] ph_reg;    // 0 off, 1 wait, 2 low, 3 high
  //////////////////////////////////////////////////////////////////////////
  // Request drops after preemption and stays off until re-armed
  assign lreq_n_out = ~(want_in & ~gone_reg);
  always @(posedge clk_in) begin
    prev_reg <= lgnt_n_in;
    gone_reg <= want_in & (gone_reg | (lgnt_n_in & ~prev_reg));
  end
  // Owner drives strobe for whole tenure, low on invalidation addresses
  assign leads_oe_out = ~&lgnt_n_in;
  assign leads_n_out  = ~inval_in;
  //////////////////////////////////////////////////////////////////////////
  // Ready: skip first T2, low one clock, high one clock, then release
  always @(posedge clk_in) begin
    case (ph_reg)
      2'h0: begin
        if (start_in) begin
          cnt_reg <= {1'b0, wait_in} + 3'h2;
          ph_reg  <= 2'h1;
        end
      end
      2'h1: begin
        cnt_reg <= cnt_reg - 3'h1;
        if (cnt_reg == 3'h0) ph_reg <= 2'h2;
      end
      default: ph_reg <= ph_reg + 2'h1;
    endcase
  end
  // Released line reads high through the pull-up
  assign lrdy_n_out = (ph_reg != 2'h2);
  initial ph_reg = 2'h0;
  initial gone_reg = 2'h0;
endmodule : lbc_device_model

// ==== bench/local_bus_arbitration_and_ready_bench.sv ====
// Self-checking bench for the local-bus controller
module local_bus_arbitration_and_ready_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in = 0;
  logic       reset_in = 1;
  logic [1:0] want = 0, lreq_n, lgnt_n, m_wait = 0;
  logic       lrdy_n, leads_n, leads_oe, m_leads, m_oe, m_inval = 0, leads_w;
  logic       start = 0, wr = 0, inval = 0, ca = 0, la = 0, fast = 0;
  logic       dma = 0, memr = 0, memw = 0, lken_n, rdyrtn_n, mio, mio_oe, busy, seen;
  logic       done, owned;  // Cycle-done pulse and ownership flag
  logic       exp_q[$];  // Expected cache enable at each ready return
  int         num_errors = 0;
  int         checked = 0;
  always #2 clk_in = ~clk_in;
  // Open-drain style strobe: controller, else owner, else pull-up
  assign leads_w = leads_oe ? leads_n : (m_oe ? m_leads : 1'b1);
  lbc_controller #(.NUM_SLOTS(2), .GRANT_LIMIT(4)) u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .lreq_n_in(lreq_n), .lgnt_n_out(lgnt_n),
    .lrdy_n_in(lrdy_n), .rdyrtn_n_out(rdyrtn_n), .lken_n_out(lken_n),
    .leads_n_out(leads_n), .leads_oe_out(leads_oe), .leads_n_in(leads_w),
    .mio_out(mio), .mio_oe_out(mio_oe), .cyc_start_in(start), .cyc_write_in(wr),
    .cyc_inval_in(inval), .cyc_cacheable_in(ca), .cyc_last_in(la),
    .dma_active_in(dma), .dma_memr_in(memr), .dma_memw_in(memw),
    .fast_rdyrtn_in(fast), .cyc_busy_out(busy), .cyc_done_out(done),
    .bus_owned_out(owned), .leads_seen_out(seen));
  lbc_device_model u_dev (
    .clk_in(clk_in), .want_in(want), .lgnt_n_in(lgnt_n), .lreq_n_out(lreq_n),
    .start_in(start), .wait_in(m_wait), .lrdy_n_out(lrdy_n), .inval_in(m_inval),
    .leads_n_out(m_leads), .leads_oe_out(m_oe));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk_flag(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  // Grant compare waits a bounded time for the expected pattern
  task automatic chk_gnt(input logic [1:0] e);
    checked++;
    repeat (40) if (lgnt_n !== e) @(negedge clk_in);
    if (lgnt_n !== e) begin
      num_errors++;
      $display("wrong value grant expected %b seen %b", e, lgnt_n);
      end_sim();
    end
  endtask : chk_gnt
  task automatic wait_busy(input logic v);
    repeat (100) if (busy !== v) @(negedge clk_in);
    if (busy !== v) begin
      num_errors++;
      end_sim();
    end
  endtask : wait_busy
  // One CPU cycle; expected cache enable noted before launch
  task automatic cpu_cycle(input logic [3:0] k);
    {fast, wr, la, ca} = k;
    m_wait = 2'($urandom_range(3));
    exp_q.push_back(~(ca & la & ~wr));
    start = 1;
    @(negedge clk_in);
    start = 0;
    if (wr) chk_flag("strobe on write", 1'b1, leads_n);
    wait_busy(1'b0);
    @(negedge clk_in);
  endtask : cpu_cycle
  //////////////////////////////////////////////////////////////////////////
  // Monitor: each ready return takes the oldest note
  always @(negedge clk_in) begin
    if (!reset_in && rdyrtn_n === 1'b0) begin
      chk_flag("cycle done", 1'b1, done);
      if (exp_q.size() == 0) chk_flag("spare return", 1'b1, rdyrtn_n);
      else chk_flag("cache enable", exp_q.pop_front(), lken_n);
    end
  end
  initial begin
    void'($urandom(47036));
    repeat (10) @(negedge clk_in);
    reset_in = 0;
    chk_flag("reset cache enable", 1'b1, lken_n);
    chk_flag("reset strobe enable", 1'b1, leads_oe);
    chk_gnt(2'b11);
    want = 2'b10;
    m_inval = 1;
    chk_gnt(2'b01);
    chk_flag("bus owned", 1'b1, owned);
    repeat (6) @(negedge clk_in);
    chk_flag("strobe release", 1'b0, leads_oe);
    chk_flag("strobe seen", 1'b1, seen);
    want = 2'b11;
    chk_gnt(2'b10);
    want = 2'b00;
    m_inval = 0;
    chk_gnt(2'b11);
    chk_flag("bus free", 1'b0, owned);
    inval = 1;
    repeat (4) @(negedge clk_in);
    chk_flag("controller strobe", 1'b0, leads_n);
    for (int i = 0; i < 16; i++) cpu_cycle(4'(i));
    for (int i = 0; i < 3; i++) begin
      {dma, memr, memw} = {1'b1, i == 0, i == 1};
      repeat (4) @(negedge clk_in);
      chk_flag("status enable", 1'b1, mio_oe);
      chk_flag("status", i < 2, mio);
    end
    dma = 0;
    repeat (4) @(negedge clk_in);
    chk_flag("status off", 1'b0, mio_oe);
    chk_flag("returns missing", 1'b1, exp_q.size() == 0);
    end_sim();
  end
endmodule : local_bus_arbitration_and_ready_bench
